// ===== include/trim_loader_pkg.sv
/*
 * Shared constants and types of the temperature-indexed trim loader:
 * register offsets, flash byte map, reset values and timing.
 * Assumes a byte-wide flash of 2048 locations and a 50 MHz core clock.
 */
package trim_loader_pkg;

    // Core clock and time base
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_TIME_US;

    // Register port offsets
    localparam logic [5:0] REG_PRIMARY_CFG = 6'h00;
    localparam logic [5:0] REG_SECONDARY_CFG = 6'h04;
    localparam logic [5:0] REG_OFFSET_TRIM = 6'h08;
    localparam logic [5:0] REG_SPAN_TRIM = 6'h0C;
    localparam logic [5:0] REG_OFFSET_TEMPCO = 6'h10;
    localparam logic [5:0] REG_SPAN_TEMPCO = 6'h14;
    localparam logic [5:0] REG_POWER_UP = 6'h18;
    localparam logic [5:0] REG_TEMP_INDEX = 6'h1C;
    localparam logic [5:0] REG_STATUS = 6'h20;
    localparam logic [5:0] REG_COMMAND = 6'h24;
    localparam logic [5:0] REG_USER_ADDR = 6'h28;
    localparam logic [5:0] REG_USER_DATA = 6'h2C;

    // Command bits
    localparam int CMD_RELOAD_BIT = 0;
    localparam int CMD_REFRESH_BIT = 1;
    localparam int CMD_USER_READ_BIT = 2;

    // Status bits
    localparam int STAT_ERASE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    // Field positions
    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 5;
    localparam int PERIOD_LSB = 0;
    localparam int PERIOD_W = 4;

    // Flash byte map
    localparam logic [10:0] OFFSET_TABLE_BASE = 11'h000;
    localparam logic [10:0] OFFSET_TABLE_LAST = 11'h15F;
    localparam logic [10:0] SPAN_TABLE_BASE = 11'h200;
    localparam logic [10:0] SPAN_TABLE_LAST = 11'h35F;
    localparam logic [10:0] PRIMARY_CFG_ADDR = 11'h600;
    localparam logic [10:0] SECONDARY_CFG_ADDR = 11'h602;
    localparam logic [10:0] OFFSET_TEMPCO_ADDR = 11'h604;
    localparam logic [10:0] SPAN_TEMPCO_ADDR = 11'h606;
    localparam logic [10:0] POWER_UP_ADDR = 11'h608;
    localparam logic [10:0] USER_BASE = 11'h700;
    localparam int USER_BYTES = 256;

    // Temperature index limits
    localparam int TABLE_ENTRIES = 176;
    localparam logic [7:0] TEMP_INDEX_MIN = 8'h00;
    localparam logic [7:0] TEMP_INDEX_MAX = 8'hAF;
    localparam int USER_POINTS_MAX = 110;

    // Reset values
    localparam logic [15:0] TRIM_RESET = 16'h0000;
    localparam logic [15:0] SECONDARY_RESET = 16'h0003;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Loader items, in flash read order
    typedef enum logic [2:0] {
        ITEM_PRIMARY = 3'd0,
        ITEM_SECONDARY = 3'd1,
        ITEM_OFFSET_TC = 3'd2,
        ITEM_SPAN_TC = 3'd3,
        ITEM_POWER_UP = 3'd4,
        ITEM_OFFSET_TBL = 3'd5,
        ITEM_SPAN_TBL = 3'd6,
        ITEM_USER = 3'd7
    } load_item_e;

    // Loader states, Gray along the read path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ_HI = 2'b01,
        ST_READ_LO = 2'b11,
        ST_STORE = 2'b10
    } load_state_e;

    // The four trim DAC codes
    typedef struct packed {
        logic [15:0] offset_trim_word;
        logic [15:0] span_trim_word;
        logic [15:0] offset_tempco_word;
        logic [15:0] span_tempco_word;
    } trim_set_s;

endpackage : trim_loader_pkg

// ===== sim/tb_temp_indexed_trim_loader.sv
/* Self-checking bench for the trim loader with a flash model.
   Assumes a 20-cycle millisecond and a 2 ms refresh period from flash. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_temp_indexed_trim_loader
    import trim_loader_pkg::*;
;
    logic core_clk, resetn, reg_wr, reg_rd, flash_rd, flash_erase_busy, rd_seen;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, power_up_setup_word, ex;
    logic [10:0] flash_addr;
    logic [7:0] flash_rdata, idx;
    logic signed [9:0] temp_code;
    logic [GAIN_W-1:0] gain_code;
    trim_set_s trim_words;
    int fails, tests_run, cycles;
    logic [15:0] exp_q [$];
    string name_q [$];
    string nm;
    temp_indexed_trim_loader #(.MS_CYCLES(20)) dut_u (.core_clk(core_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_rdata(flash_rdata), .flash_erase_busy(flash_erase_busy), .temp_code(temp_code),
        .trim_words(trim_words), .gain_code(gain_code), .power_up_setup_word(power_up_setup_word));
    trim_flash_model flash_u (.core_clk(core_clk), .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_rdata(flash_rdata));
    ////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Expected word, worked out from the flash image, and expected index, clamped from the raw code
    function automatic logic [15:0] fw(input logic [10:0] a);
        return {flash_u.mem[a], flash_u.mem[a + 11'h001]};
    endfunction : fw
    function automatic logic [7:0] clampi(input int t);
        return (t < 0) ? TEMP_INDEX_MIN : (t > 175) ? TEMP_INDEX_MAX : 8'(t);
    endfunction : clampi
    // One register bus cycle
    task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [15:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [15:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask : rd
    // Wait for the span fetch of a refresh so that the loader is idle next
    task automatic sync();
        int n;
        n = 0;
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        while (!(flash_rd && flash_addr[10:9] == 2'b01) && n < 200)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (3) @(posedge core_clk);
    endtask : sync
    ////////////////////////////////////////
    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Read data checked against the oldest note; cycle ceiling
    always @(posedge core_clk)
    begin
        if (rd_seen)
        begin
            ex = exp_q.pop_front();
            nm = name_q.pop_front();
            `CHK(nm, ex, reg_rdata)
        end
        rd_seen <= reg_rd;
        cycles++;
        if (cycles == 10000)
        begin
            fails++;
            report_and_stop();
        end
    end
    // Main sequence
    initial
    begin
        int tv [10];
        int t;
        logic [15:0] w;
        {resetn, reg_wr, reg_rd, flash_erase_busy, rd_seen} = 5'h00;
        {reg_addr, reg_wdata, temp_code} = 0;
        {fails, tests_run, cycles} = 0;
        void'($urandom(74));
        for (int i = 0; i < 2048; i++)
            flash_u.mem[i] = 8'($urandom);
        flash_u.mem[11'h603] = 8'h01;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (40) @(posedge core_clk);
        // Boot image and unmapped place
        rd(REG_PRIMARY_CFG, fw(PRIMARY_CFG_ADDR), "primary");
        rd(REG_SECONDARY_CFG, fw(SECONDARY_CFG_ADDR), "secondary");
        rd(REG_SPAN_TEMPCO, fw(SPAN_TEMPCO_ADDR), "span tempco");
        rd(REG_POWER_UP, fw(POWER_UP_ADDR), "power-up");
        rd(6'h30, 16'h0000, "unmapped");
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        w = fw(PRIMARY_CFG_ADDR);
        `CHK("gain", w[GAIN_W-1:0], gain_code)
        `CHK("power-up pins", fw(POWER_UP_ADDR), power_up_setup_word)
        // Temperature sweep with saturation at both ends
        tv = '{-5, 0, 1, 109, 175, 176, 300, 0, 0, 0};
        for (int i = 0; i < 10; i++)
        begin
            t = (i < 7) ? tv[i] : int'($urandom_range(175, 0));
            temp_code <= 10'(t);
            repeat (95) @(posedge core_clk);
            idx = clampi(t);
            `CHK("offset trim", fw(11'(2 * idx)), trim_words.offset_trim_word)
            `CHK("span trim", fw(SPAN_TABLE_BASE + 11'(2 * idx)), trim_words.span_trim_word)
            rd(REG_TEMP_INDEX, {8'h00, idx}, "index");
            rd(REG_OFFSET_TRIM, fw(11'(2 * idx)), "offset reg");
            bus(1'b0, 1'b0, 6'h00, 16'h0000);
        end
        // Full-range tempco codes
        sync();
        bus(1'b1, 1'b0, REG_OFFSET_TEMPCO, 16'hFFFF);
        bus(1'b1, 1'b0, REG_SPAN_TEMPCO, 16'h0000);
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        `CHK("offset tempco", 16'hFFFF, trim_words.offset_tempco_word)
        `CHK("span tempco", 16'h0000, trim_words.span_tempco_word)
        // Every gain step
        for (int g = 0; g < 32; g++)
        begin
            if (g % 8 == 0)
                sync();
            bus(1'b1, 1'b0, REG_PRIMARY_CFG, {11'($urandom), 5'(g)});
            bus(1'b0, 1'b0, 6'h00, 16'h0000);
            @(posedge core_clk);
            `CHK("gain step", 5'(g), gain_code)
        end
        // Erase: commands dropped, refresh held off
        sync();
        flash_erase_busy <= 1'b1;
        temp_code <= 10'h014;
        bus(1'b1, 1'b0, REG_SPAN_TEMPCO, 16'h1234);
        bus(1'b1, 1'b0, REG_COMMAND, 16'h0001);
        rd(REG_STATUS, 16'h0001, "status");
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (100) @(posedge core_clk);
        rd(REG_TEMP_INDEX, {8'h00, idx}, "frozen index");
        flash_erase_busy <= 1'b0;
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (95) @(posedge core_clk);
        rd(REG_TEMP_INDEX, 16'h0014, "resumed index");
        rd(REG_SPAN_TEMPCO, 16'h0000, "dropped write");
        // Reload all from flash
        sync();
        bus(1'b1, 1'b0, REG_COMMAND, 16'h0001);
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (30) @(posedge core_clk);
        rd(REG_PRIMARY_CFG, fw(PRIMARY_CFG_ADDR), "reloaded primary");
        rd(REG_OFFSET_TEMPCO, fw(OFFSET_TEMPCO_ADDR), "reloaded tempco");
        // Refresh on command, well before the next timed one, then a user byte
        sync();
        temp_code <= 10'h0A0;
        bus(1'b1, 1'b0, REG_COMMAND, 16'h0002);
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (10) @(posedge core_clk);
        rd(REG_TEMP_INDEX, 16'h00A0, "refresh now index");
        `CHK("refresh now trim", fw(11'h140), trim_words.offset_trim_word)
        sync();
        w = 16'($urandom_range(255, 0));
        bus(1'b1, 1'b0, REG_USER_ADDR, w);
        bus(1'b1, 1'b0, REG_COMMAND, 16'h0004);
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (8) @(posedge core_clk);
        rd(REG_USER_DATA, {8'h00, flash_u.mem[USER_BASE + w[10:0]]}, "user byte");
        bus(1'b0, 1'b0, 6'h00, 16'h0000);
        repeat (3) @(posedge core_clk);
        report_and_stop();
    end
endmodule : tb_temp_indexed_trim_loader

// ===== sim/temp_indexed_trim_loader_sva.sv
/* Port checker for the trim loader, bound to every instance.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module temp_indexed_trim_loader_sva
    import trim_loader_pkg::*;
#(
    parameter int MS_CYCLES = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Flash array
    input wire logic [10:0] flash_addr,
    input wire logic flash_rd,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_erase_busy,
    // Temperature and trims
    input wire logic signed [9:0] temp_code,
    input wire trim_set_s trim_words,
    input wire logic [GAIN_W-1:0] gain_code,
    input wire logic [15:0] power_up_setup_word
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Flash fetch order and table addressing
    property p_even_hi;
        $rose(flash_rd) && flash_addr < 11'h400 |-> !flash_addr[0];
    endproperty
    a_even_hi: assert property (p_even_hi) else $error("table fetch on odd byte");
    property p_lo_follows;
        $rose(flash_rd) && flash_addr[10:8] != 3'h7 |=> flash_rd && flash_addr == $past(flash_addr) + 11'h001;
    endproperty
    a_lo_follows: assert property (p_lo_follows) else $error("low byte fetch missing");
    property p_span_after;
        $rose(flash_rd) && flash_addr <= OFFSET_TABLE_LAST |->
            ##3 flash_rd && flash_addr == $past(flash_addr, 3) + SPAN_TABLE_BASE;
    endproperty
    a_span_after: assert property (p_span_after) else $error("span fetch not paired");
    property p_table_range;
        flash_rd && flash_addr < 11'h400 |->
            flash_addr <= OFFSET_TABLE_LAST || (flash_addr >= SPAN_TABLE_BASE && flash_addr <= SPAN_TABLE_LAST);
    endproperty
    a_table_range: assert property (p_table_range) else $error("table fetch out of range");
    property p_erase_idle;
        flash_erase_busy && !flash_rd ##1 flash_erase_busy && !flash_rd |=> !flash_rd;
    endproperty
    a_erase_idle: assert property (p_erase_idle) else $error("flash read during erase");
    ////////////////////////////////////////
    // Register reads against the outputs
    property p_gain;
        reg_rd && reg_addr == REG_PRIMARY_CFG |=> gain_code == reg_rdata[GAIN_W-1:0];
    endproperty
    a_gain: assert property (p_gain) else $error("gain code differs from word");
    property p_offset_rd;
        $past(reg_rd) && $past(reg_addr) == REG_OFFSET_TRIM |-> reg_rdata == $past(trim_words.offset_trim_word);
    endproperty
    a_offset_rd: assert property (p_offset_rd) else $error("offset trim read differs");
    property p_span_tc_rd;
        $past(reg_rd) && $past(reg_addr) == REG_SPAN_TEMPCO |-> reg_rdata == $past(trim_words.span_tempco_word);
    endproperty
    a_span_tc_rd: assert property (p_span_tc_rd) else $error("span tempco read differs");
    property p_index_max;
        $past(reg_rd) && $past(reg_addr) == REG_TEMP_INDEX |-> reg_rdata <= {8'h00, TEMP_INDEX_MAX};
    endproperty
    a_index_max: assert property (p_index_max) else $error("index beyond top entry");
    property p_status_erase;
        $past(reg_rd) && $past(reg_addr) == REG_STATUS |-> reg_rdata[STAT_ERASE_BIT] == $past(flash_erase_busy);
    endproperty
    a_status_erase: assert property (p_status_erase) else $error("erase status wrong");
endmodule : temp_indexed_trim_loader_sva

bind temp_indexed_trim_loader temp_indexed_trim_loader_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_erase_busy(flash_erase_busy),
    .temp_code(temp_code), .trim_words(trim_words), .gain_code(gain_code),
    .power_up_setup_word(power_up_setup_word)
);

// ===== sim/trim_flash_model.sv
/* Byte-wide flash array seen by the trim loader.
   Assumes reads strobed on core_clk with data due one cycle later. */
`timescale 1ns/1ps
module trim_flash_model
    import trim_loader_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Flash port
    input wire logic [10:0] flash_addr,
    input wire logic flash_rd,
    output logic [7:0] flash_rdata
);
    // Byte array, filled by the bench
    logic [7:0] mem [0:2047];
    ////////////////////////////////////////
    // One-cycle read; each idle cycle inverts the last value, so a stale byte shows again every second idle cycle
    always_ff @(posedge core_clk)
    begin
        if (flash_rd)
            flash_rdata <= mem[flash_addr];
        else
            flash_rdata <= ~flash_rdata;
    end
endmodule : trim_flash_model

// ===== verilog/temp_indexed_trim_loader.sv
/*
 * Temperature-indexed trim loader: fetches configuration and trim words from
 * a byte-wide flash, refreshes offset and span trims from tables indexed by
 * temperature, and exposes everything on a plain register port.
 * Assumes flash read data one cycle after the read strobe, and a temperature
 * code and erase-busy flag produced on the same clock.
 */
`timescale 1ns/1ps

module temp_indexed_trim_loader
    import trim_loader_pkg::*;
#(
    parameter int MS_CYCLES = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Flash array
    output logic [10:0] flash_addr,
    output logic flash_rd,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_erase_busy,
    // Temperature converter, signed raw index
    input wire logic signed [9:0] temp_code,
    // Analog trims and amplifier
    output trim_set_s trim_words,
    output logic [GAIN_W-1:0] gain_code,
    output logic [15:0] power_up_setup_word
);

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    logic [15:0] primary_config_word;
    logic [15:0] secondary_config_word;
    logic [7:0] temperature_index;
    logic [7:0] user_addr_reg;
    logic [7:0] user_data_reg;
    logic [31:0] ms_cnt_reg;
    logic [PERIOD_W-1:0] period_cnt_reg;
    logic refresh_due_reg;
    logic boot_due_reg;
    load_state_e state_reg;
    load_item_e item_reg;
    load_item_e last_item_reg;
    logic [7:0] hi_byte_reg;
    logic [15:0] word_assembled;
    logic cmd_ok;
    logic cmd_reload;
    logic cmd_refresh;
    logic cmd_user;
    logic ms_tick;
    logic start_boot;
    logic start_refresh;
    logic start_user;
    logic [7:0] index_clamped;
    logic [10:0] item_base;
    logic sw_wr;
    logic [15:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // Command acceptance

    // Writes are commands; all are dropped while the flash is erasing
    assign cmd_ok = reg_wr && !flash_erase_busy;
    assign sw_wr = cmd_ok && (state_reg == ST_IDLE);
    assign cmd_reload = sw_wr && (reg_addr == REG_COMMAND) && reg_wdata[CMD_RELOAD_BIT];
    assign cmd_refresh = sw_wr && (reg_addr == REG_COMMAND) && reg_wdata[CMD_REFRESH_BIT];
    assign cmd_user = sw_wr && (reg_addr == REG_COMMAND) && reg_wdata[CMD_USER_READ_BIT];

    // Loader starts, highest priority first; never while erasing
    assign start_boot = (state_reg == ST_IDLE) && !flash_erase_busy && (boot_due_reg || cmd_reload);
    assign start_refresh = (state_reg == ST_IDLE) && !flash_erase_busy && !start_boot
                           && (refresh_due_reg || cmd_refresh);
    assign start_user = (state_reg == ST_IDLE) && !flash_erase_busy && !start_boot && !start_refresh && cmd_user;

    ////////////////////////////////////////////////////////////////////////
    // Refresh timer

    // Millisecond enable pulse
    assign ms_tick = (ms_cnt_reg == MS_LAST);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ms_cnt_reg <= '0;
        else if (ms_tick)
            ms_cnt_reg <= '0;
        else
            ms_cnt_reg <= ms_cnt_reg + 32'd1;
    end

    // Period is (field + 1) ms; reset value of the field gives 4 ms
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            period_cnt_reg <= '0;
            refresh_due_reg <= 1'b0;
        end
        else
        begin
            if (ms_tick)
            begin
                if (period_cnt_reg >= secondary_config_word[PERIOD_LSB +: PERIOD_W])
                    period_cnt_reg <= '0;
                else
                    period_cnt_reg <= period_cnt_reg + 4'd1;
            end
            // Set wins over the clear of a starting refresh
            if (ms_tick && period_cnt_reg >= secondary_config_word[PERIOD_LSB +: PERIOD_W])
                refresh_due_reg <= 1'b1;
            else if (start_refresh)
                refresh_due_reg <= 1'b0;
        end
    end

    // Full load from flash once after reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            boot_due_reg <= 1'b1;
        else if (start_boot)
            boot_due_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Temperature index

    // Clamp the raw code into the table range
    always_comb
    begin
        if (temp_code < 10'sd0)
            index_clamped = TEMP_INDEX_MIN;
        else if (temp_code > $signed({2'b00, TEMP_INDEX_MAX}))
            index_clamped = TEMP_INDEX_MAX;
        else
            index_clamped = temp_code[7:0];
    end

    // Index is sampled at the start of every table load
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            temperature_index <= TEMP_INDEX_MIN;
        else if (start_boot || start_refresh)
            temperature_index <= index_clamped;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash loader

    // Upper-byte address of the current item
    always_comb
    begin
        case (item_reg)
            ITEM_PRIMARY: item_base = PRIMARY_CFG_ADDR;
            ITEM_SECONDARY: item_base = SECONDARY_CFG_ADDR;
            ITEM_OFFSET_TC: item_base = OFFSET_TEMPCO_ADDR;
            ITEM_SPAN_TC: item_base = SPAN_TEMPCO_ADDR;
            ITEM_POWER_UP: item_base = POWER_UP_ADDR;
            // Index at most 0xAF keeps reads inside 0x000-0x15F and 0x200-0x35F
            ITEM_OFFSET_TBL: item_base = OFFSET_TABLE_BASE + {2'b00, temperature_index, 1'b0};
            ITEM_SPAN_TBL: item_base = SPAN_TABLE_BASE + {2'b00, temperature_index, 1'b0};
            ITEM_USER: item_base = USER_BASE + {3'b000, user_addr_reg};
            default: item_base = PRIMARY_CFG_ADDR;
        endcase
    end

    // Read strobe in the two read states; lower address is the upper half
    always_comb
    begin
        flash_rd = (state_reg == ST_READ_HI) || (state_reg == ST_READ_LO);
        flash_addr = (state_reg == ST_READ_LO) ? (item_base + 11'd1) : item_base;
    end

    assign word_assembled = {hi_byte_reg, flash_rdata};

    // Sequencer: read upper byte, read lower byte, store, next item
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            item_reg <= ITEM_PRIMARY;
            last_item_reg <= ITEM_PRIMARY;
            hi_byte_reg <= BYTE_RESET;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start_boot)
                    begin
                        item_reg <= ITEM_PRIMARY;
                        last_item_reg <= ITEM_SPAN_TBL;
                        state_reg <= ST_READ_HI;
                    end
                    else if (start_refresh)
                    begin
                        item_reg <= ITEM_OFFSET_TBL;
                        last_item_reg <= ITEM_SPAN_TBL;
                        state_reg <= ST_READ_HI;
                    end
                    else if (start_user)
                    begin
                        item_reg <= ITEM_USER;
                        last_item_reg <= ITEM_USER;
                        state_reg <= ST_READ_HI;
                    end
                end
                ST_READ_HI: state_reg <= ST_READ_LO;
                ST_READ_LO:
                begin
                    hi_byte_reg <= flash_rdata;
                    state_reg <= ST_STORE;
                end
                ST_STORE:
                begin
                    if (item_reg == last_item_reg)
                        state_reg <= ST_IDLE;
                    else
                    begin
                        item_reg <= load_item_e'(item_reg + 3'd1);
                        state_reg <= ST_READ_HI;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration words

    // Loaded from flash or written by software; loader owns them while busy
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            primary_config_word <= TRIM_RESET;
            secondary_config_word <= SECONDARY_RESET;
            trim_words <= '0;
            power_up_setup_word <= TRIM_RESET;
            user_addr_reg <= BYTE_RESET;
            user_data_reg <= BYTE_RESET;
        end
        else if (state_reg == ST_STORE)
        begin
            case (item_reg)
                ITEM_PRIMARY: primary_config_word <= word_assembled;
                ITEM_SECONDARY: secondary_config_word <= word_assembled;
                ITEM_OFFSET_TC: trim_words.offset_tempco_word <= word_assembled;
                ITEM_SPAN_TC: trim_words.span_tempco_word <= word_assembled;
                ITEM_POWER_UP: power_up_setup_word <= word_assembled;
                ITEM_OFFSET_TBL: trim_words.offset_trim_word <= word_assembled;
                ITEM_SPAN_TBL: trim_words.span_trim_word <= word_assembled;
                ITEM_USER: user_data_reg <= hi_byte_reg;
                default: user_data_reg <= user_data_reg;
            endcase
        end
        else if (sw_wr)
        begin
            // Full 16-bit range accepted for every trim word
            case (reg_addr)
                REG_PRIMARY_CFG: primary_config_word <= reg_wdata;
                REG_SECONDARY_CFG: secondary_config_word <= reg_wdata;
                REG_OFFSET_TRIM: trim_words.offset_trim_word <= reg_wdata;
                REG_SPAN_TRIM: trim_words.span_trim_word <= reg_wdata;
                REG_OFFSET_TEMPCO: trim_words.offset_tempco_word <= reg_wdata;
                REG_SPAN_TEMPCO: trim_words.span_tempco_word <= reg_wdata;
                REG_POWER_UP: power_up_setup_word <= reg_wdata;
                REG_USER_ADDR: user_addr_reg <= reg_wdata[7:0];
                default: user_addr_reg <= user_addr_reg;
            endcase
        end
    end

    // Gain step select, 32 steps
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            gain_code <= '0;
        else
            gain_code <= primary_config_word[GAIN_LSB +: GAIN_W];
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr)
            REG_PRIMARY_CFG: rdata_next = primary_config_word;
            REG_SECONDARY_CFG: rdata_next = secondary_config_word;
            REG_OFFSET_TRIM: rdata_next = trim_words.offset_trim_word;
            REG_SPAN_TRIM: rdata_next = trim_words.span_trim_word;
            REG_OFFSET_TEMPCO: rdata_next = trim_words.offset_tempco_word;
            REG_SPAN_TEMPCO: rdata_next = trim_words.span_tempco_word;
            REG_POWER_UP: rdata_next = power_up_setup_word;
            REG_TEMP_INDEX: rdata_next = {8'h00, temperature_index};
            REG_STATUS: rdata_next = {14'h0000, state_reg != ST_IDLE, flash_erase_busy};
            REG_USER_ADDR: rdata_next = {8'h00, user_addr_reg};
            REG_USER_DATA: rdata_next = {8'h00, user_data_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 16'h0000;
    end

endmodule : temp_indexed_trim_loader
